// ### hdl/rtcksf_device.sv
// Purpose: device end: keyed special function, charger config, leap year
// Assumes: link pins come from outside this clock domain
// Notes: frame = write flag, address, data on writes only; reads answer after frame
`timescale 1ns/1ps
`include "rtcksf_consts.svh"
`default_nettype none
module rtcksf_device #(
  parameter int CLK_HZ = `RTCKSF_CLK_HZ
) (
  input wire logic clk,
  input wire logic resetn,
  rtcksf_link_if.device link,
  input wire logic main_supply_ok,
  input wire logic ppm_tick,
  input wire logic [7:0] year_count,
  output logic trickle_fet_on,
  output logic charger_active,
  output logic cal_out,
  output logic leap_year,
  output logic protect_open
);
  import rtcksf_pkg::*;

  localparam int FAST_HALF = CLK_HZ / (2 * `RTCKSF_CAL_FAST_HZ);
  localparam int SLOW_HALF = CLK_HZ / (2 * `RTCKSF_CAL_SLOW_HZ);

  logic [2:0] clk_sync_r;
  logic [2:0] frame_sync_r;
  logic [1:0] mosi_sync_r;
  logic [1:0] pwr_sync_r;
  logic [16:0] shift_r;
  logic [4:0] bit_cnt_r;
  logic wr_stb_r;
  logic rd_stb_r;
  rtcksf_byte_t addr_r;
  rtcksf_byte_t data_r;
  rtcksf_byte_t charger_config_r;
  rtcksf_byte_t second_switch_r;
  rtcksf_byte_t special_ctrl_r;
  rtcksf_key_state_t key_state_r;
  rtcksf_byte_t resp_data_r;
  logic resp_valid_r;
  logic [31:0] cal_cnt_r;
  logic cal_r;
  logic fet_r;
  logic chg_r;
  logic leap_r;
  logic open_r;
  logic pwr_r;

  function automatic logic is_leap(input logic [7:0] bcd_year);
    // Tens digit odd needs units 2/6; tens even needs units 0/4/8
    if (bcd_year[4])
      is_leap = (bcd_year[3:0] == 4'h2) || (bcd_year[3:0] == 4'h6);
    else
      is_leap = (bcd_year[3:0] == 4'h0) || (bcd_year[3:0] == 4'h4) ||
        (bcd_year[3:0] == 4'h8);
  endfunction : is_leap

  wire link_rise = clk_sync_r[1] & ~clk_sync_r[2];
  wire frame_on = frame_sync_r[1];
  wire frame_end = ~frame_sync_r[1] & frame_sync_r[2];
  wire powered = pwr_sync_r[1];

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      clk_sync_r <= 3'h0;
      frame_sync_r <= 3'h0;
      mosi_sync_r <= 2'h0;
      pwr_sync_r <= 2'h0;
    end
    else
    begin
      clk_sync_r <= {clk_sync_r[1:0], link.link_clk};
      frame_sync_r <= {frame_sync_r[1:0], link.link_frame};
      mosi_sync_r <= {mosi_sync_r[0], link.link_mosi};
      pwr_sync_r <= {pwr_sync_r[0], main_supply_ok};
    end

  // Frame shifter; whole frames seen on backup supply are dropped
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      shift_r <= 17'h0;
      bit_cnt_r <= 5'h0;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      addr_r <= 8'h00;
      data_r <= 8'h00;
    end
    else
    begin
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      if (!frame_on)
      begin
        bit_cnt_r <= 5'h0;
        if (frame_end && powered)
        begin
          if (bit_cnt_r == 5'd17 && shift_r[16])
          begin
            wr_stb_r <= 1'b1;
            addr_r <= shift_r[15:8];
            data_r <= shift_r[7:0];
          end
          else if (bit_cnt_r == 5'd9 && !shift_r[8])
          begin
            rd_stb_r <= 1'b1;
            addr_r <= shift_r[7:0];
          end
        end
      end
      else if (link_rise && bit_cnt_r != 5'd17)
      begin
        shift_r <= {shift_r[15:0], mosi_sync_r[1]};
        bit_cnt_r <= bit_cnt_r + 5'd1;
      end
    end

  // Unlock sequencer
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      key_state_r <= RTCKSF_KEY_IDLE;
    else if (wr_stb_r)
    begin
      unique case (key_state_r)
        RTCKSF_KEY_IDLE:
          if (addr_r == `RTCKSF_ADDR_KEY_FIRST &&
              data_r == `RTCKSF_KEY_FIRST_VALUE)
            key_state_r <= RTCKSF_KEY_HALF;
        RTCKSF_KEY_HALF:
          if (addr_r == `RTCKSF_ADDR_KEY_SECOND &&
              data_r == `RTCKSF_KEY_SECOND_VALUE)
            key_state_r <= RTCKSF_KEY_OPEN;
          else
            key_state_r <= RTCKSF_KEY_IDLE;
        RTCKSF_KEY_OPEN:
          key_state_r <= RTCKSF_KEY_IDLE;
        default:
          key_state_r <= RTCKSF_KEY_IDLE;
      endcase
    end

  // Register writes; reserved bits cleared on write, reset values not masked
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      charger_config_r <= `RTCKSF_RESET_CHARGER_CONFIG;
      second_switch_r <= `RTCKSF_RESET_SECOND_SWITCH;
      special_ctrl_r <= `RTCKSF_RESET_SPECIAL_CTRL;
    end
    else if (wr_stb_r)
    begin
      if (addr_r == `RTCKSF_ADDR_CHARGER_CONFIG)
        charger_config_r <= data_r & `RTCKSF_MASK_CHARGER_CONFIG;
      if (addr_r == `RTCKSF_ADDR_SECOND_SWITCH)
        second_switch_r <= data_r & `RTCKSF_MASK_SECOND_SWITCH;
      if (addr_r == `RTCKSF_ADDR_SPECIAL_CTRL &&
          key_state_r == RTCKSF_KEY_OPEN)
        special_ctrl_r <= data_r & `RTCKSF_MASK_SPECIAL_CTRL;
    end

  // Read answers; keys read as zero
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      resp_data_r <= 8'h00;
      resp_valid_r <= 1'b0;
    end
    else
    begin
      resp_valid_r <= rd_stb_r;
      if (rd_stb_r)
        unique case (addr_r)
          `RTCKSF_ADDR_CHARGER_CONFIG: resp_data_r <= charger_config_r;
          `RTCKSF_ADDR_SECOND_SWITCH: resp_data_r <= second_switch_r;
          `RTCKSF_ADDR_SPECIAL_CTRL: resp_data_r <= special_ctrl_r;
          `RTCKSF_ADDR_KEY_FIRST,
          `RTCKSF_ADDR_KEY_SECOND:
            resp_data_r <= `RTCKSF_KEY_READ_VALUE;
          `RTCKSF_ADDR_YEAR: resp_data_r <= year_count;
          default: resp_data_r <= `RTCKSF_UNMAPPED_READ;
        endcase
    end

  // Calibration output; slow clock paced by ppm-trimmed tick, fast by clk
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      cal_cnt_r <= 32'h0;
      cal_r <= 1'b0;
    end
    else if (special_ctrl_r[`RTCKSF_BIT_FORCE_ONE_HZ])
    begin
      if (ppm_tick)
      begin
        if (cal_cnt_r >= 32'(SLOW_HALF - 1))
        begin
          cal_cnt_r <= 32'h0;
          cal_r <= ~cal_r;
        end
        else
          cal_cnt_r <= cal_cnt_r + 32'h1;
      end
    end
    else if (cal_cnt_r >= 32'(FAST_HALF - 1))
    begin
      cal_cnt_r <= 32'h0;
      cal_r <= ~cal_r;
    end
    else
      cal_cnt_r <= cal_cnt_r + 32'h1;

  // Status outputs; not gated by supply, counting continues on backup
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      fet_r <= 1'b0;
      chg_r <= 1'b0;
      leap_r <= 1'b0;
      open_r <= 1'b0;
      pwr_r <= 1'b0;
    end
    else
    begin
      fet_r <= charger_config_r[`RTCKSF_BIT_FET_BYPASS];
      chg_r <= (charger_config_r[3:0] == `RTCKSF_CHARGER_ON_CODE) &&
        charger_config_r[`RTCKSF_BIT_FET_BYPASS] &&
        second_switch_r[`RTCKSF_BIT_SECOND_SWITCH];
      leap_r <= is_leap(year_count);
      open_r <= (key_state_r == RTCKSF_KEY_OPEN);
      pwr_r <= powered;
    end

  assign trickle_fet_on = fet_r;
  assign charger_active = chg_r;
  assign cal_out = cal_r;
  assign leap_year = leap_r;
  assign protect_open = open_r;
  assign link.resp_data = resp_data_r;
  assign link.resp_valid = resp_valid_r;
  assign link.main_power_ok = pwr_r;
endmodule : rtcksf_device
`default_nettype wire

// ### hdl/rtcksf_consts.svh
// Purpose: constants for the keyed special function register block
// Assumes: byte-wide registers on a serial-style link
// Notes: offsets, reset values, keys, field positions, timing counts
`ifndef RTCKSF_CONSTS_SVH
`define RTCKSF_CONSTS_SVH
`define RTCKSF_ADDR_CHARGER_CONFIG 8'h09
`define RTCKSF_ADDR_KEY_FIRST 8'h20
`define RTCKSF_ADDR_KEY_SECOND 8'h21
`define RTCKSF_ADDR_SPECIAL_CTRL 8'h22
`define RTCKSF_ADDR_SECOND_SWITCH 8'h08
`define RTCKSF_ADDR_YEAR 8'h06
`define RTCKSF_RESET_CHARGER_CONFIG 8'haa
`define RTCKSF_RESET_SPECIAL_CTRL 8'h00
`define RTCKSF_RESET_SECOND_SWITCH 8'h90
`define RTCKSF_KEY_FIRST_VALUE 8'h5e
`define RTCKSF_KEY_SECOND_VALUE 8'hc7
`define RTCKSF_KEY_READ_VALUE 8'h00
`define RTCKSF_CHARGER_ON_CODE 4'h5
`define RTCKSF_BIT_FET_BYPASS 6
`define RTCKSF_BIT_SECOND_SWITCH 5
`define RTCKSF_BIT_FORCE_ONE_HZ 0
`define RTCKSF_MASK_CHARGER_CONFIG 8'h4f
`define RTCKSF_MASK_SPECIAL_CTRL 8'h01
`define RTCKSF_MASK_SECOND_SWITCH 8'h20
`define RTCKSF_MASK_YEAR 8'hff
`define RTCKSF_UNMAPPED_READ 8'h00
`define RTCKSF_CLK_HZ 100000000
`define RTCKSF_CAL_FAST_HZ 512
`define RTCKSF_CAL_SLOW_HZ 1
`define RTCKSF_SETTLE_MS 1000
`define RTCKSF_LINK_HALF_CYCLES 8
`endif

// ### hdl/rtcksf_pkg.sv
// Purpose: shared types for the keyed special function register block
// Assumes: constants come from the header
// Notes: link frame phases
package rtcksf_pkg;
  typedef logic [7:0] rtcksf_byte_t;
  typedef enum logic [1:0] {
    RTCKSF_KEY_IDLE = 2'b00,
    RTCKSF_KEY_HALF = 2'b01,
    RTCKSF_KEY_OPEN = 2'b10
  } rtcksf_key_state_t;
  typedef enum logic [2:0] {
    RTCKSF_H_IDLE = 3'b000,
    RTCKSF_H_SHIFT = 3'b001,
    RTCKSF_H_WAIT = 3'b010,
    RTCKSF_H_DONE = 3'b011,
    RTCKSF_H_SETTLE = 3'b100
  } rtcksf_host_state_t;
endpackage : rtcksf_pkg

// ### hdl/rtcksf_link_if.sv
// Purpose: link between host controller and keyed register device
// Assumes: host makes link_clk; frame is 1 write bit, 8 address bits,
//   8 data bits on writes only, msb first, changed on the host's falling edge and sampled on its rising edge; the device
//   answers read data on resp_data after the frame, marked by resp_valid
// Notes: main_power_ok is the supply state seen by both ends
`timescale 1ns/1ps
`default_nettype none
interface rtcksf_link_if;
  logic link_clk;
  logic link_frame;
  logic link_mosi;
  logic [7:0] resp_data;
  logic resp_valid;
  logic main_power_ok;
  modport host (output link_clk, output link_frame, output link_mosi,
    input resp_data, input resp_valid, input main_power_ok);
  modport device (input link_clk, input link_frame, input link_mosi,
    output resp_data, output resp_valid, output main_power_ok);
endinterface : rtcksf_link_if
`default_nettype wire

// ### hdl/rtcksf_host.sv
// Purpose: host end: shifts register frames to the device
// Assumes: device answers in its own clock domain; inputs synchronised
// Notes: flags timekeeping reads untrusted on reads_trusted for a settle time after power return
`timescale 1ns/1ps
`include "rtcksf_consts.svh"
`default_nettype none
module rtcksf_host #(
  parameter int HALF_CYCLES = `RTCKSF_LINK_HALF_CYCLES,
  parameter int SETTLE_CYCLES = `RTCKSF_SETTLE_MS * (`RTCKSF_CLK_HZ / 1000)
) (
  input wire logic clk,
  input wire logic resetn,
  rtcksf_link_if.host link,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic busy,
  output logic rvalid,
  output logic reads_trusted
);
  import rtcksf_pkg::*;

  rtcksf_host_state_t state_r;
  logic [16:0] shift_r;
  logic [4:0] bits_r;
  logic [7:0] div_r;
  logic lclk_r;
  logic frame_r;
  logic is_rd_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [1:0] vld_sync_r;
  logic [1:0] pwr_sync_r;
  logic vld_d_r;
  logic [31:0] settle_r;
  logic trusted_r;
  logic [9:0] wait_r;

  // Bits that may carry ones for each register; the rest go out as zero
  function automatic logic [7:0] wr_mask(input logic [7:0] a);
    case (a)
      `RTCKSF_ADDR_CHARGER_CONFIG: wr_mask = `RTCKSF_MASK_CHARGER_CONFIG;
      `RTCKSF_ADDR_SPECIAL_CTRL: wr_mask = `RTCKSF_MASK_SPECIAL_CTRL;
      `RTCKSF_ADDR_SECOND_SWITCH: wr_mask = `RTCKSF_MASK_SECOND_SWITCH;
      default: wr_mask = 8'hff;
    endcase
  endfunction : wr_mask

  wire vld_rise = vld_sync_r[1] & ~vld_d_r;

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      vld_sync_r <= 2'h0;
      pwr_sync_r <= 2'h0;
      vld_d_r <= 1'b0;
    end
    else
    begin
      vld_sync_r <= {vld_sync_r[0], link.resp_valid};
      pwr_sync_r <= {pwr_sync_r[0], link.main_power_ok};
      vld_d_r <= vld_sync_r[1];
    end

  // Frame engine; reserved write bits are sent as zero
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      state_r <= RTCKSF_H_IDLE;
      shift_r <= 17'h0;
      bits_r <= 5'h0;
      div_r <= 8'h0;
      lclk_r <= 1'b0;
      frame_r <= 1'b0;
      is_rd_r <= 1'b0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      wait_r <= 10'h0;
    end
    else
    begin
      rvalid_r <= 1'b0;
      unique case (state_r)
        RTCKSF_H_IDLE:
          if (wr || rd)
          begin
            shift_r <= wr ? {1'b1, addr, wdata & wr_mask(addr)} :
              {1'b0, addr, 8'h00};
            bits_r <= wr ? 5'd17 : 5'd9;
            is_rd_r <= rd & ~wr;
            frame_r <= 1'b1;
            div_r <= 8'h0;
            state_r <= RTCKSF_H_SHIFT;
          end
        RTCKSF_H_SHIFT:
          if (div_r == 8'(HALF_CYCLES - 1))
          begin
            div_r <= 8'h0;
            if (!lclk_r)
            begin
              if (bits_r == 5'h0)
              begin
                frame_r <= 1'b0;
                wait_r <= 10'h0;
                state_r <= is_rd_r ? RTCKSF_H_WAIT : RTCKSF_H_DONE;
              end
              else
                lclk_r <= 1'b1;
            end
            else
            begin
              lclk_r <= 1'b0;
              bits_r <= bits_r - 5'd1;
              shift_r <= {shift_r[15:0], 1'b0};
            end
          end
          else
            div_r <= div_r + 8'h1;
        RTCKSF_H_WAIT:
          // Device on backup never answers; give up after a bound
          if (vld_rise)
          begin
            rdata_r <= link.resp_data;
            rvalid_r <= 1'b1;
            state_r <= RTCKSF_H_DONE;
          end
          else if (wait_r == 10'h3ff)
            state_r <= RTCKSF_H_DONE;
          else
            wait_r <= wait_r + 10'h1;
        RTCKSF_H_DONE:
          state_r <= RTCKSF_H_SETTLE;
        RTCKSF_H_SETTLE:
          state_r <= RTCKSF_H_IDLE;
        default:
          state_r <= RTCKSF_H_IDLE;
      endcase
    end

  // Timekeeping values trusted only after settle time on main supply
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      settle_r <= 32'h0;
      trusted_r <= 1'b0;
    end
    else if (!pwr_sync_r[1])
    begin
      settle_r <= 32'h0;
      trusted_r <= 1'b0;
    end
    else if (settle_r >= 32'(SETTLE_CYCLES - 1))
      trusted_r <= 1'b1;
    else
      settle_r <= settle_r + 32'h1;

  logic busy_r;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      busy_r <= 1'b0;
    else
      busy_r <= (state_r != RTCKSF_H_IDLE) || wr || rd;

  assign link.link_clk = lclk_r;
  assign link.link_frame = frame_r;
  assign link.link_mosi = shift_r[16];
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign busy = busy_r;
  assign reads_trusted = trusted_r;
endmodule : rtcksf_host
`default_nettype wire

// ### test/rtcksf_props.sv
// Purpose: link checks between the host and device ends
// Assumes: one clock drives both ends; frames decoded off the wire
// Notes: end_r marks the cycle after a frame has dropped
`timescale 1ns/1ps
`include "rtcksf_consts.svh"
`default_nettype none
module rtcksf_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_mosi,
  input wire logic [7:0] resp_data,
  input wire logic resp_valid,
  input wire logic main_power_ok
);
  logic lc_r, fr_r, end_r;
  logic [16:0] sh_r;
  logic [4:0] n_r;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      lc_r <= 1'b0;
      fr_r <= 1'b0;
      end_r <= 1'b0;
      sh_r <= '0;
      n_r <= '0;
    end
    else
    begin
      lc_r <= link_clk;
      fr_r <= link_frame;
      end_r <= fr_r & ~link_frame;
      // Last rise may land on the edge where the frame drops
      if (link_frame & ~fr_r)
        n_r <= '0;
      else if ((link_frame | fr_r) & link_clk & ~lc_r)
      begin
        n_r <= n_r + 5'd1;
        sh_r <= {sh_r[15:0], link_mosi};
      end
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence rd_ok;
    end_r && n_r == 5'd9 && main_power_ok;
  endsequence
  sequence wr_end;
    end_r && n_r == 5'd17;
  endsequence
  a_frame_shape: assert property (
    end_r |-> (n_r == 5'd17 && sh_r[16]) || (n_r == 5'd9 && !sh_r[8]))
    else $error("frame length and kind disagree");
  a_read_answer: assert property (
    rd_ok |-> ##[0:6] resp_valid)
    else $error("read frame got no answer");
  a_resp_pulse: assert property (
    resp_valid |=> !resp_valid)
    else $error("answer longer than one cycle");
  a_write_silent: assert property (
    wr_end |=> !resp_valid [*6])
    else $error("write frame answered");
  a_backup_silent: assert property (
    end_r && !main_power_ok |=> !resp_valid [*6])
    else $error("answer while on backup supply");
  a_key_zero: assert property (
    rd_ok ##0 sh_r[7:1] == 7'h10 |-> ##[0:6] resp_valid && resp_data == 8'h00)
    else $error("key register read not zero");
  a_ctrl_masked: assert property (
    rd_ok ##0 sh_r[7:0] == 8'h22 |-> ##[0:6] resp_valid && !resp_data[7:1])
    else $error("reserved control bits set");
  a_unmapped_zero: assert property (
    rd_ok ##0 sh_r[7:0] > 8'h22 |-> ##[0:6] resp_valid && resp_data == 8'h00)
    else $error("unmapped read not zero");
  a_mosi_hold: assert property (
    link_frame && link_clk && lc_r |-> $stable(link_mosi))
    else $error("data bit moved while link clock high");
endmodule : rtcksf_props
`default_nettype wire

// ### test/tb_rtc_keyed_special_function_regs.sv
// Purpose: bench for host and device ends joined by the link
// Assumes: shortened settle and calibration counts
// Notes: expected values come from the register map
`timescale 1ns/1ps
`include "rtcksf_consts.svh"
`default_nettype none
module tb_rtc_keyed_special_function_regs;
  import rtcksf_pkg::*;
  localparam int CK = 2048;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sup = 1'b1;
  logic ppm = 1'b0;
  logic [7:0] yr = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rv_seen = 1'b0;
  logic [7:0] rdata;
  logic busy, rvalid, trusted, fet, chg, cal, leap, opn;
  int n_fail = 0;
  int check_count = 0;
  rtcksf_link_if lk ();
  rtcksf_host #(.HALF_CYCLES(8), .SETTLE_CYCLES(100)) i_rtcksf_host (
    .clk(clk), .resetn(resetn), .link(lk.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .busy(busy),
    .rvalid(rvalid), .reads_trusted(trusted));
  rtcksf_device #(.CLK_HZ(CK)) i_rtcksf_device (
    .clk(clk), .resetn(resetn), .link(lk.device), .main_supply_ok(sup),
    .ppm_tick(ppm), .year_count(yr), .trickle_fet_on(fet),
    .charger_active(chg), .cal_out(cal), .leap_year(leap),
    .protect_open(opn));
  rtcksf_props i_rtcksf_props (
    .clk(clk), .resetn(resetn), .link_clk(lk.link_clk),
    .link_frame(lk.link_frame), .link_mosi(lk.link_mosi),
    .resp_data(lk.resp_data), .resp_valid(lk.resp_valid),
    .main_power_ok(lk.main_power_ok));
  initial
    forever #5 clk = ~clk;
  // Trimmed time base ticks every other cycle
  always @(posedge clk)
    ppm <= ~ppm;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle();
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (busy !== 1'b0 && i < 2000);
    if (busy !== 1'b0)
    begin
      n_fail++;
      $display("mismatch at %0t: host stayed busy", $time);
    end
  endtask : idle
  task automatic wreg(input rtcksf_byte_t a, input rtcksf_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    idle();
    repeat (4) @(posedge clk);
  endtask : wreg
  task automatic chkr(input rtcksf_byte_t a, input rtcksf_byte_t e);
    int i;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (rvalid !== 1'b1 && i < 1500);
    rv_seen = (rvalid === 1'b1);
    if (sup)
    begin
      chk(rv_seen, 1'b1);
      chk(rdata, e);
    end
    idle();
  endtask : chkr
  task automatic unlock(input rtcksf_byte_t k1, input rtcksf_byte_t k2);
    wreg(8'h20, k1);
    wreg(8'h21, k2);
  endtask : unlock
  task automatic period(output int p);
    logic q;
    int n, t0;
    q = cal;
    n = 0;
    t0 = -1;
    p = 0;
    while (p == 0 && n < 9000)
    begin
      @(posedge clk);
      n++;
      if (cal && !q)
        if (t0 < 0)
          t0 = n;
        else
          p = n - t0;
      q = cal;
    end
  endtask : period
  task automatic t_regs();
    chkr(8'h09, 8'haa);
    chkr(8'h22, 8'h00);
    chkr(8'h20, 8'h00);
    chkr(8'h21, 8'h00);
    chkr(8'h30, 8'h00);
    chkr(8'h08, 8'h90);
    chk(fet, 1'b0);
    chk(chg, 1'b0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_chg();
    logic [7:0] c [5] = '{8'h45, 8'h05, 8'h44, 8'h4a, 8'h45};
    logic [7:0] s [5] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h00};
    for (int k = 0; k < 5; k++)
    begin
      wreg(8'h08, s[k]);
      wreg(8'h09, c[k]);
      chk(fet, c[k][6]);
      chk(chg, c[k][6] && c[k][3:0] == 4'h5 && s[k][5]);
    end
    chkr(8'h08, 8'h00);
    wreg(8'h09, 8'hff);
    chkr(8'h09, 8'h4f);
    $display("test charger done");
  endtask : t_chg
  task automatic t_key();
    unlock(8'h5e, 8'hc7);
    chk(opn, 1'b1);
    chkr(8'h20, 8'h00);
    wreg(8'h22, 8'hff);
    chkr(8'h22, 8'h01);
    chk(opn, 1'b0);
    wreg(8'h22, 8'h00);
    chkr(8'h22, 8'h01);
    unlock(8'h5e, 8'hc6);
    wreg(8'h22, 8'h00);
    chkr(8'h22, 8'h01);
    wreg(8'h20, 8'h5e);
    unlock(8'h00, 8'hc7);
    wreg(8'h22, 8'h00);
    chkr(8'h22, 8'h01);
    wreg(8'h20, 8'h5e);
    wreg(8'h09, 8'h00);
    wreg(8'h21, 8'hc7);
    wreg(8'h22, 8'h00);
    chkr(8'h22, 8'h01);
    unlock(8'h5e, 8'hc7);
    wreg(8'h22, 8'h00);
    chkr(8'h22, 8'h00);
    $display("test keys done");
  endtask : t_key
  task automatic t_leap();
    logic [7:0] y [8] = '{8'h00, 8'h04, 8'h12, 8'h96,
      8'h01, 8'h10, 8'h14, 8'h98};
    for (int k = 0; k < 8; k++)
    begin
      yr <= y[k];
      repeat (3) @(posedge clk);
      chk(leap, k < 4);
    end
    chkr(8'h06, 8'h98);
    $display("test leap done");
  endtask : t_leap
  task automatic t_cal();
    int p;
    period(p);
    chk(16'(p), 16'(CK / 512));
    unlock(8'h5e, 8'hc7);
    wreg(8'h22, 8'h01);
    period(p);
    chk(16'(p), 16'(CK * 2));
    $display("test calibration done");
  endtask : t_cal
  task automatic t_bkp();
    int p, i;
    sup <= 1'b0;
    repeat (4) @(posedge clk);
    wreg(8'h09, 8'h45);
    chkr(8'h09, 8'h00);
    chk(rv_seen, 1'b0);
    chk(fet, 1'b0);
    period(p);
    chk(16'(p), 16'(CK * 2));
    sup <= 1'b1;
    repeat (10) @(posedge clk);
    chk(trusted, 1'b0);
    i = 0;
    while (trusted !== 1'b1 && i < 300)
    begin
      @(posedge clk);
      i++;
    end
    chk(trusted, 1'b1);
    chkr(8'h09, 8'h00);
    wreg(8'h09, 8'h45);
    chkr(8'h09, 8'h45);
    $display("test backup done");
  endtask : t_bkp
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_chg();
    t_key();
    t_leap();
    t_cal();
    t_bkp();
    close_out();
  end
  initial
  begin
    #600000;
    n_fail++;
    close_out();
  end
endmodule : tb_rtc_keyed_special_function_regs
`default_nettype wire
